// ---- design/pdm_pkg.sv ----
// Package with register map, field layout, reset values and states of the power-down controller.
package pdm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_CLOCK_CONTROL = 8'h04;
    localparam logic [7:0] OFS_MODULE_STOP_CONTROL = 8'h08;
    localparam logic [7:0] OFS_POWER_STATUS = 8'h0c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int STANDBY_SELECT_BIT = 7;
    localparam int STAB_SEL_LSB = 4;
    localparam int OUTPUT_HOLD_BIT = 3;
    localparam int STANDBY_SPARE_BIT = 0;
    localparam int CLK_STOP_BIT = 7;
    localparam int CLK_SPARE_BIT = 6;
    localparam logic [7:0] STANDBY_CONTROL_RST = 8'h08;
    localparam logic [7:0] SYSTEM_CLOCK_CONTROL_RST = 8'h00;
    localparam logic [15:0] MODULE_STOP_RST = 16'h3fff;
    // Stop bits that gate a real module: transfer controller, timers, converters, serial channels.
    localparam logic [15:0] STOP_EFFECT_MASK = 16'h76e0;
    // Modules that are reset rather than frozen while stopped: serial channels and A/D.
    localparam logic [15:0] STOP_RESET_MASK = 16'h02e0;
    localparam logic [15:0] STOP_ALL = 16'hffff;
    localparam logic [15:0] STOP_ALL_BUT_TIMER8 = 16'hefff;

    // ------------------------------------------------------------------
    // Clock select codes and timing counts
    // ------------------------------------------------------------------
    localparam logic [2:0] CLK_SEL_FULL = 3'h0;
    localparam logic [2:0] CLK_SEL_DIV32 = 3'h5;
    localparam logic [2:0] STAB_SEL_SHORT = 3'h7;
    localparam logic [2:0] STAB_SEL_RESERVED = 3'h6;
    localparam int STAB_CNT_SHORT = 16;
    localparam int STAB_CNT_W = 19;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_SW_STANDBY,
        ST_OSC_WAIT,
        ST_HW_STANDBY
    } pdm_state_e;

    typedef struct packed {
        logic nmi;
        logic [2:0] irq;
        logic [2:0] irqEnable;
        logic [2:0] irqCpuMasked;
        logic [2:0] irqTransferSource;
    } pdm_wake_s;

endpackage

// ---- design/pdm_clk_divider.sv ----
// Medium-speed clock divider producing the bus master clock enable.
`timescale 1ns/1ns
`default_nettype none
module pdm_clk_divider #(
    parameter int CNT_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic [2:0] divSel,
    input wire logic restart,
    // Enable pulse
    output logic tick
);
    import pdm_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    // ------------------------------------------------------------------
    // Division mask per select code
    // ------------------------------------------------------------------
    always_comb begin
        case (divSel)
            3'h1: mask = CNT_W'(1);  // [RULE_01]
            3'h2: mask = CNT_W'(3);  // [RULE_01]
            3'h3: mask = CNT_W'(7);  // [RULE_01]
            3'h4: mask = CNT_W'(15); // [RULE_01]
            CLK_SEL_DIV32: mask = CNT_W'(31); // [RULE_01]
            default: mask = '0;
        endcase
    end

    // Restarting the phase on a select change keeps every pulse whole.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (restart) begin
            cnt_r <= '0; // [RULE_25]
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    assign tick = ((cnt_r & mask) == '0) && !restart;

endmodule // pdm_clk_divider
`default_nettype wire

// ---- design/pdm_controller.sv ----
// Power-down mode controller: clock speed, sleep, module stop and standby sequencing.
//
// Behaviour
// [RULE_01] Clock select picks full, /2, /4, /8, /16, /32.
// [RULE_02] Nonzero select takes effect after bus cycle.
// [RULE_03] Only CPU and transfer unit get divided clock.
// [RULE_04] Bus states counted in bus master clock ticks.
// [RULE_05] Zero select returns full speed at cycle end.
// [RULE_06] Sleep with standby select clear halts CPU.
// [RULE_07] Sleep ends on reset or accepted interrupt.
// [RULE_08] Wake keeps the selected divided clock.
// [RULE_09] Reset or watchdog overflow cancels medium speed.
// [RULE_10] Standby pin low forces hardware standby.
// [RULE_11] Stop bits gate modules at bus cycle end.
// [RULE_12] Stop register loads 3fff on reset, hardware standby.
// [RULE_13] Stopped serial and A/D are reset, others hold.
// [RULE_14] Register access to stopped modules is blocked.
// [RULE_15] Stop bit to module mapping; spare bits inert.
// [RULE_16] Sleep with all stopped halts bus and ports.
// [RULE_17] Sleep with standby select stops all, oscillator too.
// [RULE_18] Standby wake restarts oscillator, waits, then resumes.
// [RULE_19] Only enabled, unmasked, non-transfer interrupts wake standby.
// [RULE_20] Reset pin in standby restarts clocks at once.
// [RULE_21] Stabilization select gives documented wait counts.
// [RULE_22] Software picks a wait of at least 8 ms.
// [RULE_23] Standby select stays set after interrupt wake.
// [RULE_24] Output hold bit chooses hold or float in standby.
// [RULE_25] Clock switches only whole pulses at cycle boundary.
`timescale 1ns/1ns
`default_nettype none
module pdm_controller #(
    parameter int STAB_CNT_0 = 8192,
    parameter int STAB_CNT_1 = 16384,
    parameter int STAB_CNT_2 = 32768,
    parameter int STAB_CNT_3 = 65536,
    parameter int STAB_CNT_4 = 131072,
    parameter int STAB_CNT_5 = 262144
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU and system events
    input wire logic busCycleEnd,
    input wire logic sleepExec,
    input wire logic cpuIntAccept,
    input wire logic wdtOverflow,
    input wire logic hardwareStandbyPin_n,
    input wire pdm_pkg::pdm_wake_s wake,
    // Clock and gating outputs
    output logic masterClkEn,
    output logic periphClkEn,
    output logic cpuHalt,
    output logic oscRun,
    output logic [15:0] moduleClkEn,
    output logic [15:0] moduleRst,
    output logic [15:0] moduleRegBlock,
    output logic busCtrlHalt,
    output logic busOutFloat,
    output logic intExcStart,
    output logic hwStandby
);
    import pdm_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [7:0] standbyCtrl_r;
    logic [7:0] clkCtrl_r;
    logic [15:0] stopCtrl_r;
    logic [2:0] clkActive_r;
    logic [15:0] stopActive_r;
    pdm_state_e state_r;
    pdm_state_e state_nxt;
    logic [STAB_CNT_W-1:0] stabCnt_r;
    logic [STAB_CNT_W-1:0] stabTarget;
    logic divTick;
    logic clkApply;
    logic wakeOk;
    logic wrEn;
    logic standby_select;
    logic output_hold_enable;
    logic [2:0] stabSel;

    assign standby_select = standbyCtrl_r[STANDBY_SELECT_BIT];
    assign output_hold_enable = standbyCtrl_r[OUTPUT_HOLD_BIT];
    assign stabSel = standbyCtrl_r[STAB_SEL_LSB +: 3];
    assign wrEn = psel && penable && pready && pwrite && !pslverr;
    assign clkApply = busCycleEnd && (clkActive_r != clkCtrl_r[2:0]);

    // ------------------------------------------------------------------
    // APB slave: one wait state, error on unmapped offsets
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
                OFS_STANDBY_CONTROL: prdata <= {24'h0, standbyCtrl_r & 8'hf9};
                OFS_SYSTEM_CLOCK_CONTROL: prdata <= {24'h0, clkCtrl_r & 8'hc7};
                OFS_MODULE_STOP_CONTROL: prdata <= {16'h0, stopCtrl_r};
                OFS_POWER_STATUS: prdata <= {8'h0, stopActive_r, 5'h0, clkActive_r};
                default: begin
                    prdata <= '0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            standbyCtrl_r <= STANDBY_CONTROL_RST; // [RULE_24]
        end else if (!hardwareStandbyPin_n) begin
            standbyCtrl_r <= STANDBY_CONTROL_RST;
        end else if (wrEn && paddr == OFS_STANDBY_CONTROL) begin
            // Standby select clears only on a write of zero, a reset or the hardware standby pin.
            standbyCtrl_r <= pwdata[7:0] & 8'hf9; // [RULE_23]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkCtrl_r <= SYSTEM_CLOCK_CONTROL_RST; // [RULE_09]
        end else if (!hardwareStandbyPin_n || wdtOverflow) begin
            clkCtrl_r <= SYSTEM_CLOCK_CONTROL_RST; // [RULE_09]
        end else if (wrEn && paddr == OFS_SYSTEM_CLOCK_CONTROL) begin
            clkCtrl_r <= pwdata[7:0] & 8'hc7;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stopCtrl_r <= MODULE_STOP_RST; // [RULE_12]
        end else if (!hardwareStandbyPin_n) begin
            stopCtrl_r <= MODULE_STOP_RST; // [RULE_12]
        end else if (wrEn && paddr == OFS_MODULE_STOP_CONTROL) begin
            stopCtrl_r <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Bus cycle boundary updates of clock select and module stop
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkActive_r <= CLK_SEL_FULL;
        end else if (!hardwareStandbyPin_n || wdtOverflow) begin
            clkActive_r <= CLK_SEL_FULL; // [RULE_09]
        end else if (busCycleEnd) begin
            clkActive_r <= clkCtrl_r[2:0]; // [RULE_02] [RULE_05] [RULE_25]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stopActive_r <= MODULE_STOP_RST;
        end else if (!hardwareStandbyPin_n) begin
            stopActive_r <= MODULE_STOP_RST;
        end else if (busCycleEnd) begin
            stopActive_r <= stopCtrl_r; // [RULE_11]
        end
    end

    pdm_clk_divider #(
        .CNT_W(5)
    ) u_divider (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .divSel(clkActive_r),
        .restart(clkApply),
        .tick(divTick)
    );

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    always_comb begin
        case (stabSel)
            3'h0: stabTarget = STAB_CNT_W'(STAB_CNT_0); // [RULE_21]
            3'h1: stabTarget = STAB_CNT_W'(STAB_CNT_1);
            3'h2: stabTarget = STAB_CNT_W'(STAB_CNT_2);
            3'h3: stabTarget = STAB_CNT_W'(STAB_CNT_3);
            3'h4: stabTarget = STAB_CNT_W'(STAB_CNT_4);
            STAB_SEL_SHORT: stabTarget = STAB_CNT_W'(STAB_CNT_SHORT);
            default: stabTarget = STAB_CNT_W'(STAB_CNT_5);
        endcase
    end

    assign wakeOk = wake.nmi ||
        (|(wake.irq & wake.irqEnable & ~wake.irqCpuMasked & ~wake.irqTransferSource)); // [RULE_19]

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleepExec) begin
                    state_nxt = standby_select ? ST_SW_STANDBY : ST_SLEEP; // [RULE_06] [RULE_17]
                end
            end
            ST_SLEEP: begin
                if (cpuIntAccept) begin
                    state_nxt = ST_RUN; // [RULE_07] [RULE_08]
                end
            end
            ST_SW_STANDBY: begin
                if (wakeOk) begin
                    state_nxt = ST_OSC_WAIT; // [RULE_18]
                end
            end
            ST_OSC_WAIT: begin
                if (stabCnt_r >= stabTarget - STAB_CNT_W'(1)) begin
                    state_nxt = ST_RUN; // [RULE_18] [RULE_08]
                end
            end
            ST_HW_STANDBY: state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
        if (!hardwareStandbyPin_n) begin
            state_nxt = ST_HW_STANDBY; // [RULE_10]
        end
    end

    // Reset returns to run with the oscillator on, which also ends standby.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN; // [RULE_20]
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stabCnt_r <= '0;
        end else if (state_r == ST_OSC_WAIT) begin
            stabCnt_r <= stabCnt_r + STAB_CNT_W'(1);
        end else begin
            stabCnt_r <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            masterClkEn <= 1'b1;
            cpuHalt <= 1'b0;
            oscRun <= 1'b1; // [RULE_20]
            periphClkEn <= 1'b1;
        end else begin
            // Bus access states elapse on this enable only.
            masterClkEn <= divTick && state_nxt == ST_RUN; // [RULE_03] [RULE_04]
            cpuHalt <= state_nxt != ST_RUN; // [RULE_06]
            oscRun <= state_nxt != ST_SW_STANDBY && state_nxt != ST_HW_STANDBY; // [RULE_17]
            periphClkEn <= state_nxt == ST_RUN || state_nxt == ST_SLEEP; // [RULE_03]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            moduleClkEn <= ~MODULE_STOP_RST & STOP_EFFECT_MASK;
            moduleRst <= MODULE_STOP_RST & STOP_RESET_MASK;
            moduleRegBlock <= MODULE_STOP_RST & STOP_EFFECT_MASK;
        end else if (state_nxt == ST_HW_STANDBY) begin
            moduleClkEn <= '0;
            moduleRst <= STOP_EFFECT_MASK;
            moduleRegBlock <= STOP_EFFECT_MASK;
        end else begin
            if (state_nxt == ST_RUN || state_nxt == ST_SLEEP) begin
                moduleClkEn <= ~stopActive_r & STOP_EFFECT_MASK; // [RULE_11] [RULE_15]
            end else begin
                moduleClkEn <= '0; // [RULE_17]
            end
            if (state_nxt == ST_SW_STANDBY || state_nxt == ST_OSC_WAIT) begin
                moduleRst <= STOP_RESET_MASK; // [RULE_17]
            end else begin
                moduleRst <= stopActive_r & STOP_RESET_MASK; // [RULE_13]
            end
            moduleRegBlock <= stopActive_r & STOP_EFFECT_MASK; // [RULE_14]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busCtrlHalt <= 1'b0;
            busOutFloat <= 1'b0;
            intExcStart <= 1'b0;
            hwStandby <= 1'b0;
        end else begin
            busCtrlHalt <= state_nxt == ST_SLEEP &&
                (stopActive_r == STOP_ALL || stopActive_r == STOP_ALL_BUT_TIMER8); // [RULE_16]
            busOutFloat <= state_nxt == ST_HW_STANDBY ||
                ((state_nxt == ST_SW_STANDBY || state_nxt == ST_OSC_WAIT) && !output_hold_enable); // [RULE_24]
            intExcStart <= state_r == ST_OSC_WAIT && state_nxt == ST_RUN; // [RULE_18]
            hwStandby <= state_nxt == ST_HW_STANDBY; // [RULE_10]
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    clk_apply_a: assert property ($changed(clkActive_r) |-> $past(busCycleEnd) || $past(wdtOverflow) // [RULE_02]
        || $past(!hardwareStandbyPin_n)) else $error("clock select changed off a cycle boundary");
    wdt_clear_a: assert property (wdtOverflow |=> clkCtrl_r[2:0] == CLK_SEL_FULL // [RULE_09]
        && clkActive_r == CLK_SEL_FULL) else $error("watchdog overflow kept medium speed");
    sleep_entry_a: assert property (state_r == ST_RUN && sleepExec && !standby_select && hardwareStandbyPin_n // [RULE_06]
        |=> state_r == ST_SLEEP && cpuHalt && oscRun) else $error("sleep entry wrong");
    sleep_exit_a: assert property (state_r == ST_SLEEP && cpuIntAccept && hardwareStandbyPin_n // [RULE_07]
        |=> state_r == ST_RUN && !cpuHalt) else $error("sleep did not end on interrupt");
    stop_load_a: assert property (!hardwareStandbyPin_n |=> stopCtrl_r == MODULE_STOP_RST && hwStandby) // [RULE_12]
        else $error("hardware standby did not load stop register");
    wake_osc_a: assert property (state_r == ST_SW_STANDBY && wakeOk && hardwareStandbyPin_n // [RULE_18]
        |=> state_r == ST_OSC_WAIT ##0 oscRun) else $error("standby wake did not restart oscillator");
    wake_gate_a: assert property (state_r == ST_SW_STANDBY && !wakeOk && hardwareStandbyPin_n // [RULE_19]
        |=> state_r == ST_SW_STANDBY && !oscRun) else $error("standby left without valid wake");
    short_wait_a: assert property (disable iff (!rst_n || !hardwareStandbyPin_n) // [RULE_21]
        state_r == ST_SW_STANDBY && wakeOk && stabSel == STAB_SEL_SHORT
        |-> ##16 state_r == ST_OSC_WAIT ##1 state_r == ST_RUN) else $error("short stabilization wait not 16 cycles");
    standby_select_keep_a: assert property (state_r == ST_OSC_WAIT ##1 state_r == ST_RUN |-> standby_select && intExcStart) // [RULE_23]
        else $error("standby select lost on wake");
    bus_float_a: assert property (busOutFloat |-> $past(state_nxt == ST_HW_STANDBY || !output_hold_enable)) // [RULE_24]
        else $error("bus floated while output hold set");
    bus_halt_a: assert property (busCtrlHalt |-> state_r == ST_SLEEP && stopActive_r[11:0] == 12'hfff) // [RULE_16]
        else $error("bus controller halted outside deep sleep");

    sleep_c: cover property (state_r == ST_SLEEP ##1 state_r == ST_RUN);
    wake_c: cover property (state_r == ST_OSC_WAIT ##1 state_r == ST_RUN);
    medium_c: cover property (clkActive_r == CLK_SEL_DIV32 && masterClkEn);

endmodule // pdm_controller
`default_nettype wire

// ---- verification/pdm_cpu_model.sv ----
// Behavioural model of the CPU side: bus cycle ends and interrupt acceptance.
`timescale 1ns/1ns
`default_nettype none
module pdm_cpu_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // From the controller
    input wire logic masterClkEn,
    input wire logic cpuHalt,
    // From the bench
    input wire logic irqReq,
    // To the controller
    output logic busCycleEnd,
    output logic cpuIntAccept
);
    logic [1:0] stateCnt_r;
    // A bus cycle lasts four bus master clock ticks; a halted CPU runs no cycles.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateCnt_r <= 2'h0;
            busCycleEnd <= 1'b0;
        end else begin
            busCycleEnd <= masterClkEn && !cpuHalt && stateCnt_r == 2'h3;
            if (masterClkEn && !cpuHalt) begin
                stateCnt_r <= stateCnt_r + 2'h1;
            end
        end
    end
    // An interrupt is taken only while cpuHalt holds the CPU halted.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuIntAccept <= 1'b0;
        end else begin
            cpuIntAccept <= irqReq && cpuHalt && !cpuIntAccept;
        end
    end
endmodule // pdm_cpu_model
`default_nettype wire

// ---- verification/tb_power_down_mode_controller.sv ----
// Self-checking testbench of the power-down mode controller.
`timescale 1ns/1ns
`default_nettype none
module tb_power_down_mode_controller;
    import pdm_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleepExec = 0, wdtOverflow = 0;
    logic hardwareStandbyPin_n = 1, irqReq = 0, er, pready, pslverr, busCycleEnd, cpuIntAccept;
    logic masterClkEn, periphClkEn, cpuHalt, oscRun, busCtrlHalt, busOutFloat, intExcStart, hwStandby;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [15:0] moduleClkEn, moduleRst, moduleRegBlock, stopVal;
    logic [2:0] sel;
    pdm_wake_s wake = '0;
    int n_errors = 0, checked = 0, cyc = 0, n, k;
    always #50 core_clk = ~core_clk;
    pdm_controller #(.STAB_CNT_0(20), .STAB_CNT_1(24), .STAB_CNT_2(28), .STAB_CNT_3(32), .STAB_CNT_4(36),
        .STAB_CNT_5(40)) uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busCycleEnd(busCycleEnd), .sleepExec(sleepExec), .cpuIntAccept(cpuIntAccept), .wdtOverflow(wdtOverflow),
        .hardwareStandbyPin_n(hardwareStandbyPin_n), .wake(wake), .masterClkEn(masterClkEn),
        .periphClkEn(periphClkEn), .cpuHalt(cpuHalt), .oscRun(oscRun), .moduleClkEn(moduleClkEn),
        .moduleRst(moduleRst), .moduleRegBlock(moduleRegBlock), .busCtrlHalt(busCtrlHalt),
        .busOutFloat(busOutFloat), .intExcStart(intExcStart), .hwStandby(hwStandby));
    pdm_cpu_model cpu (.core_clk(core_clk), .rst_n(rst_n), .masterClkEn(masterClkEn), .cpuHalt(cpuHalt),
        .irqReq(irqReq), .busCycleEnd(busCycleEnd), .cpuIntAccept(cpuIntAccept));
    // ------------------------------------------------------------------
    // Bus, comparison and closing tasks
    // ------------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Polls the status register until the applied field shows the value.
    task wait_stat(input logic [31:0] msk, input logic [31:0] v);
        n = 0;
        do begin apb(0, OFS_POWER_STATUS, 0); n++; end while ((rd & msk) !== v && n < 60);
        chk("applied status", v, rd & msk);
    endtask
    task count_ticks(input int cycles);
        k = 0;
        repeat (cycles) begin @(posedge core_clk); k += (masterClkEn === 1'b1); end
    endtask
    task pulse_sleep;
        @(posedge core_clk);
        sleepExec <= 1;
        @(posedge core_clk);
        sleepExec <= 0;
        repeat (3) @(posedge core_clk);
    endtask
    function automatic logic [15:0] gated(input logic [15:0] s);
        return s & 16'h76e0;
    endfunction
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin n_errors++; test_done(); end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hc49f4c86));
        repeat (20) @(posedge core_clk);
        rst_n <= 1;
        apb(0, OFS_STANDBY_CONTROL, 0); chk("standby_control", 32'h08, rd);
        apb(0, OFS_MODULE_STOP_CONTROL, 0); chk("module_stop_control", 32'h3fff, rd);
        apb(0, OFS_SYSTEM_CLOCK_CONTROL, 0); chk("system_clock_control", 32'h0, rd);
        chk("moduleClkEn", 32'h4000, {16'h0, moduleClkEn});
        apb(0, 8'h10, 0); chk("unmapped error", 32'h1, {31'h0, er});
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            stopVal = (i == 0) ? 16'h0 : ((i == 1) ? 16'hffff : 16'($urandom));
            apb(1, OFS_MODULE_STOP_CONTROL, {16'h0, stopVal});
            wait_stat(32'hffff00, {8'h0, stopVal, 8'h0});
            chk("moduleClkEn", {16'h0, gated(~stopVal)}, {16'h0, moduleClkEn});
            chk("moduleRst", {16'h0, stopVal & 16'h02e0}, {16'h0, moduleRst});
            chk("moduleRegBlock", {16'h0, gated(stopVal)}, {16'h0, moduleRegBlock});
        end
        $display("test module stop done");
        for (int c = 1; c <= 6; c++) begin
            sel = 3'(c % 6);
            apb(1, OFS_SYSTEM_CLOCK_CONTROL, {29'h0, sel});
            wait_stat(32'h7, {29'h0, sel});
            count_ticks(64); chk("bus clock ticks", 64 >> sel, k);
        end
        $display("test clock select done");
        for (int i = 0; i < 3; i++) begin
            sel = 3'(1 + $urandom % 5);
            stopVal = (i == 0) ? 16'hffff : ((i == 1) ? 16'hefff : 16'h0f00);
            apb(1, OFS_SYSTEM_CLOCK_CONTROL, {29'h0, sel});
            apb(1, OFS_MODULE_STOP_CONTROL, {16'h0, stopVal});
            wait_stat(32'hffff07, {8'h0, stopVal, 5'h0, sel});
            pulse_sleep();
            chk("cpuHalt", 1, cpuHalt);
            chk("periphClkEn", 1, periphClkEn);
            chk("busCtrlHalt", (i < 2), busCtrlHalt);
            count_ticks(16); chk("halted ticks", 0, k);
            n = 0; irqReq <= 1;
            do @(posedge core_clk); while (cpuHalt !== 1'b0 && ++n < 10);
            irqReq <= 0;
            chk("cpuHalt", 0, cpuHalt);
            count_ticks(64); chk("bus clock ticks", 64 >> sel, k);
        end
        $display("test sleep done");
        for (int s = 0; s < 2; s++) begin
            apb(1, OFS_STANDBY_CONTROL, (s == 1) ? 32'h88 : 32'hf0);
            pulse_sleep();
            chk("oscRun", 0, oscRun);
            chk("periphClkEn", 0, periphClkEn);
            chk("busOutFloat", !s, busOutFloat);
            chk("moduleRst", 32'h02e0, {16'h0, moduleRst});
            if (s == 1) begin
                wake.irq[0] <= 1;
                repeat (8) @(posedge core_clk);
                chk("disabled irq", 0, oscRun);
                wake.irqEnable[0] <= 1; wake.irqCpuMasked[0] <= 1;
                repeat (8) @(posedge core_clk);
                chk("masked irq", 0, oscRun);
                wake.irqCpuMasked[0] <= 0; wake.irqTransferSource[0] <= 1;
                repeat (8) @(posedge core_clk);
                chk("transfer irq", 0, oscRun);
                wake.irqTransferSource[0] <= 0;
            end else wake.nmi <= 1;
            n = 0;
            do @(posedge core_clk); while (oscRun !== 1'b1 && ++n < 20);
            n = 0;
            do begin @(posedge core_clk); n++; end while (intExcStart !== 1'b1 && n < 100);
            chk("stabilization cycles", s ? 20 : 16, n);
            wake <= '0;
            apb(0, OFS_STANDBY_CONTROL, 0); chk("standby select kept", 1, rd[7]);
            wait_stat(32'hffff07, {8'h0, 16'h0f00, 5'h0, sel});
        end
        $display("test software standby done");
        @(posedge core_clk);
        wdtOverflow <= 1;
        @(posedge core_clk);
        wdtOverflow <= 0;
        wait_stat(32'h7, 0);
        apb(1, OFS_SYSTEM_CLOCK_CONTROL, 32'h2);
        @(posedge core_clk); hardwareStandbyPin_n <= 0;
        repeat (4) @(posedge core_clk);
        chk("hwStandby", 1, hwStandby);
        chk("busOutFloat", 1, busOutFloat);
        hardwareStandbyPin_n <= 1;
        repeat (4) @(posedge core_clk);
        apb(0, OFS_MODULE_STOP_CONTROL, 0); chk("module_stop_control", 32'h3fff, rd);
        apb(0, OFS_STANDBY_CONTROL, 0); chk("standby_control", 32'h08, rd);
        $display("test watchdog and hardware standby done");
        test_done();
    end
endmodule // tb_power_down_mode_controller
`default_nettype wire
